/* tb_wkr_top.sv */
`timescale 1ns/1ps
module tb_wkr_top;
    // Clock, reset and the bundled register bus
    logic clk = 1'b0;
    logic rst = 1'b1;
    wkr_pkg::wkr_bus_type bus = '0;
    logic [7:0] rd_data;
    logic wdt_reset;
    logic reset_select;
    // Mismatch and comparison counters
    int err_count = 0;
    int checked = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    wkr_top wkr_top_inst (
        .CLK_I(clk),
        .SYS_RST_I(rst),
        .BUS_I(bus),
        .RD_DATA_O(rd_data),
        .WDT_RESET_O(wdt_reset),
        .RESET_SELECT_O(reset_select)
    );

    // Compares one byte, counting every comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Drops all strobes for one cycle
    task automatic idle();
        @(posedge clk);
        bus <= '0;
    endtask

    // One-cycle write; the strobe stays up until the next task changes the bus
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, word: w};
    endtask

    // One-cycle read, data judged in the following cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, word: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(rd_data, exp, msg);
    endtask

    // Registers and outputs after reset, plus an unmapped read
    task automatic test_reset_values();
        rd(wkr_pkg::TCS_ADDR, 8'h00, "timer status after reset");
        rd(wkr_pkg::RCS_ADDR, 8'h00, "reset status after reset");
        rd(16'h1234, 8'h00, "unmapped read");
        chk({7'h00, reset_select}, 8'h00, "select output after reset");
        $display("test reset values done");
    endtask

    // Load key copies bits 6 and 5 only, back to back with the read
    task automatic test_load_key();
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_LOAD, 8'h60}, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'h60, "load key sets both bits");
        chk({7'h00, reset_select}, 8'h01, "select output follows bit");
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_LOAD, 8'h9F}, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'h00, "load key ignores other bits");
        $display("test load key done");
    endtask

    // Byte writes and unknown keys must leave the reset register alone
    task automatic test_refused();
        wr(wkr_pkg::RCS_ADDR, 16'h0060, 1'b0);
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_LOAD, 8'h60}, 1'b0);
        rd(wkr_pkg::RCS_ADDR, 8'h00, "byte write refused");
        wr(wkr_pkg::RCS_WORD_ADDR, 16'h3C60, 1'b1);
        wr(wkr_pkg::RCS_WORD_ADDR, 16'hA55A, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'h00, "unknown key refused");
        $display("test refused done");
    endtask

    // Watchdog overflow, reset pulse, then clear key against the flag
    task automatic test_overflow();
        int n;
        int seen;
        seen = 0;
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_LOAD, 8'h40}, 1'b1);
        wr(wkr_pkg::CNT_ADDR, 16'h00FE, 1'b0);
        // Watchdog mode, running, fastest clock select
        wr(wkr_pkg::TCS_ADDR, 16'h0060, 1'b0);
        idle();
        for (n = 0; n < 40 && seen == 0; n++)
        begin
            @(posedge clk);
            #1;
            if (wdt_reset === 1'b1)
                seen = 1;
        end
        chk(seen[7:0], 8'h01, "reset pulse after overflow");
        @(posedge clk);
        #1;
        chk({7'h00, wdt_reset}, 8'h00, "reset pulse one cycle");
        // Halt before anything else changes
        wr(wkr_pkg::TCS_ADDR, 16'h0040, 1'b0);
        rd(wkr_pkg::TCS_ADDR, 8'h40, "timer status after halt");
        rd(wkr_pkg::RCS_ADDR, 8'hC0, "flag set by overflow");
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_LOAD, 8'h20}, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'hA0, "load key keeps flag");
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_CLEAR, 8'h01}, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'hA0, "clear key needs zero low byte");
        wr(wkr_pkg::RCS_WORD_ADDR, {wkr_pkg::KEY_CLEAR, wkr_pkg::CLEAR_LOW}, 1'b1);
        rd(wkr_pkg::RCS_ADDR, 8'h20, "clear key clears flag only");
        chk({7'h00, reset_select}, 8'h01, "select output kept");
        $display("test overflow done");
    endtask

    // Counter writes on consecutive cycles while ticking every second cycle
    task automatic test_write_wins();
        int i;
        // Stop first, then switch to interval mode and run
        wr(wkr_pkg::TCS_ADDR, 16'h0000, 1'b0);
        wr(wkr_pkg::TCS_ADDR, 16'h0020, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            // Extra idle shifts the tick phase for the second pass
            if (i == 1)
                idle();
            wr(wkr_pkg::CNT_ADDR, 16'h0033, 1'b0);
            wr(wkr_pkg::CNT_ADDR, 16'h0033, 1'b0);
            rd(wkr_pkg::CNT_ADDR, 8'h33, "written value beats tick");
        end
        wr(wkr_pkg::TCS_ADDR, 16'h0000, 1'b0);
        idle();
        $display("test write wins done");
    endtask

    // Interval mode at select 1: pace of the count, flag set and cleared
    task automatic test_interval();
        wr(wkr_pkg::CNT_ADDR, 16'h00FE, 1'b0);
        // Timer is stopped here, so the select may change
        wr(wkr_pkg::TCS_ADDR, 16'h0021, 1'b0);
        idle();
        rd(wkr_pkg::TCS_ADDR, 8'h21, "interval mode running");
        // Ticks every 8 clocks: the wrap lands exactly 16 clocks after start
        repeat (12) @(posedge clk);
        rd(wkr_pkg::CNT_ADDR, 8'hFF, "counter paced by select");
        rd(wkr_pkg::TCS_ADDR, 8'hA1, "interval overflow sets flag");
        chk({7'h00, wdt_reset}, 8'h00, "no reset in interval mode");
        wr(wkr_pkg::TCS_ADDR, 16'h0081, 1'b0);
        rd(wkr_pkg::TCS_ADDR, 8'h81, "writing 1 keeps flag");
        wr(wkr_pkg::TCS_ADDR, 16'h0001, 1'b0);
        rd(wkr_pkg::TCS_ADDR, 8'h01, "writing 0 clears flag");
        $display("test interval done");
    endtask

    // Prints the counts and the verdict, then stops
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        test_reset_values();
        test_load_key();
        test_refused();
        test_overflow();
        test_write_wins();
        test_interval();
        end_of_test();
    end

    // Hang guard, far beyond the hundred or so cycles the tests need
    initial
    begin
        #100000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule

/* wkr_pkg.sv */
package wkr_pkg;
    // Register byte addresses
    localparam logic [15:0] TCS_ADDR = 16'hFF74;
    localparam logic [15:0] CNT_ADDR = 16'hFF75;
    localparam logic [15:0] RCS_WORD_ADDR = 16'hFF76;
    localparam logic [15:0] RCS_ADDR = 16'hFF77;
    // Keys carried in the high byte of a word write, and the low byte the clear key needs
    localparam logic [7:0] KEY_CLEAR = 8'hA5;
    localparam logic [7:0] KEY_LOAD = 8'h5A;
    localparam logic [7:0] CLEAR_LOW = 8'h00;
    // Timer control/status field positions
    localparam int TCS_OVF = 7;
    localparam int TCS_WDMODE = 6;
    localparam int TCS_TME = 5;
    localparam int TCS_CKS_LO = 0;
    localparam int CKS_W = 3;
    // Reset control/status field positions
    localparam int RCS_OVF = 7;
    localparam int RCS_RESET_ENABLE_BIT = 6;
    localparam int RCS_RESET_SELECT_BIT = 5;
    // Counter width and its terminal value
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_RST = 8'h00;
    // Prescaler width, enough for the slowest clock select
    localparam int PRE_W = 15;
    // Bus request carried as one bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic word;
    } wkr_bus_type;
    // Reset control/status contents
    typedef struct packed {
        logic ovf;
        logic reset_enable_bit;
        logic reset_select_bit;
    } wkr_rcs_type;
endpackage

/* wkr_top.sv */
`timescale 1ns/1ps
module wkr_top #(
    parameter int PRE_W = wkr_pkg::PRE_W
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire wkr_pkg::wkr_bus_type BUS_I,
    output logic [7:0] RD_DATA_O,
    output logic WDT_RESET_O,
    output logic RESET_SELECT_O
);
    // Slowest select divides by 2 to the 2*7+1
    initial
    begin
        if (PRE_W < 2 * (2 ** wkr_pkg::CKS_W - 1) + 1)
        begin
            $error("PRE_W too small for clock select");
        end
    end

    // Prescaler tap mask: select n ticks every 2^(2n+1) clocks
    function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] cks);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++)
        begin
            if (i <= 2 * int'(cks))
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Address match used by several decoders
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        return a == ref_a;
    endfunction

    wkr_pkg::wkr_rcs_type rcs_r; // Reset control/status bits
    logic [7:0] cnt_r; // Watchdog counter
    logic [PRE_W-1:0] pre_r; // Free prescaler
    logic tcs_ovf_r; // Interval overflow flag
    logic wdmode_r; // High selects watchdog operation
    logic tme_r; // Timer enable
    logic [2:0] cks_r; // Clock select bits
    logic [7:0] rd_data_r; // Read data register
    logic wdt_reset_r; // Reset pulse register
    logic tick; // Counter clock pulse
    logic cnt_wr; // Byte write to the counter
    logic tcs_wr; // Byte write to timer control/status
    logic rcs_word_wr; // Word write to reset control/status
    logic rcs_clear; // Clear key seen
    logic rcs_load; // Load key seen
    logic overflow; // Counter wraps this cycle
    logic [7:0] tcs_byte; // Timer control/status as read
    logic [7:0] rcs_byte; // Reset control/status as read

    // Write decoding
    assign cnt_wr = BUS_I.wr && !BUS_I.word && hit(BUS_I.addr, wkr_pkg::CNT_ADDR);
    assign tcs_wr = BUS_I.wr && !BUS_I.word && hit(BUS_I.addr, wkr_pkg::TCS_ADDR);
    // Byte writes never reach the reset register
    assign rcs_word_wr = BUS_I.wr && BUS_I.word
        && hit(BUS_I.addr, wkr_pkg::RCS_WORD_ADDR);
    assign rcs_clear = rcs_word_wr && BUS_I.wdata[15:8] == wkr_pkg::KEY_CLEAR
        && BUS_I.wdata[7:0] == wkr_pkg::CLEAR_LOW;
    assign rcs_load = rcs_word_wr && BUS_I.wdata[15:8] == wkr_pkg::KEY_LOAD;

    // Counter clock from the prescaler, only while enabled
    assign tick = tme_r && &(pre_r | ~tap_mask(cks_r));
    assign overflow = tick && !cnt_wr && cnt_r == wkr_pkg::CNT_MAX;

    // Register images for reads; unused bits read zero
    always_comb
    begin
        tcs_byte = '0;
        tcs_byte[wkr_pkg::TCS_OVF] = tcs_ovf_r;
        tcs_byte[wkr_pkg::TCS_WDMODE] = wdmode_r;
        tcs_byte[wkr_pkg::TCS_TME] = tme_r;
        tcs_byte[wkr_pkg::TCS_CKS_LO +: wkr_pkg::CKS_W] = cks_r;
        rcs_byte = '0;
        rcs_byte[wkr_pkg::RCS_OVF] = rcs_r.ovf;
        rcs_byte[wkr_pkg::RCS_RESET_ENABLE_BIT] = rcs_r.reset_enable_bit;
        rcs_byte[wkr_pkg::RCS_RESET_SELECT_BIT] = rcs_r.reset_select_bit;
    end

    // Prescaler runs freely; restarts while the timer is stopped
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            pre_r <= '0;
        end
        else if (!tme_r)
        begin
            pre_r <= '0;
        end
        else
        begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Counter: a write wins over a coincident clock pulse
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            cnt_r <= wkr_pkg::CNT_RST;
        end
        else if (cnt_wr)
        begin
            cnt_r <= BUS_I.wdata[7:0];
        end
        else if (tick)
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Timer control/status; software stops the timer before changing
    // clock select or mode, else the count sequence may slip
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            wdmode_r <= 1'b0;
            tme_r <= 1'b0;
            cks_r <= '0;
        end
        else if (tcs_wr)
        begin
            wdmode_r <= BUS_I.wdata[wkr_pkg::TCS_WDMODE];
            tme_r <= BUS_I.wdata[wkr_pkg::TCS_TME];
            cks_r <= BUS_I.wdata[wkr_pkg::TCS_CKS_LO +: wkr_pkg::CKS_W];
        end
    end

    // Interval overflow flag: writing 0 clears it, a new overflow wins
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            tcs_ovf_r <= 1'b0;
        end
        else if (overflow && !wdmode_r)
        begin
            tcs_ovf_r <= 1'b1;
        end
        else if (tcs_wr && !BUS_I.wdata[wkr_pkg::TCS_OVF])
        begin
            tcs_ovf_r <= 1'b0;
        end
    end

    // Reset control/status: flag set by watchdog overflow, otherwise keyed word writes only
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rcs_r <= '0;
        end
        else
        begin
            // Overflow in watchdog mode sets the flag; set beats clear
            if (overflow && wdmode_r)
            begin
                rcs_r.ovf <= 1'b1;
            end
            else if (rcs_clear)
            begin
                rcs_r.ovf <= 1'b0;
            end
            // Any other key leaves bits 6 and 5 as they are
            if (rcs_load)
            begin
                rcs_r.reset_enable_bit <= BUS_I.wdata[wkr_pkg::RCS_RESET_ENABLE_BIT];
                rcs_r.reset_select_bit <= BUS_I.wdata[wkr_pkg::RCS_RESET_SELECT_BIT];
            end
        end
    end

    // Internal reset request on watchdog overflow when enabled
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            wdt_reset_r <= 1'b0;
        end
        else
        begin
            wdt_reset_r <= overflow && wdmode_r && rcs_r.reset_enable_bit;
        end
    end

    // Read port: plain byte reads, data in the following cycle
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rd_data_r <= '0;
        end
        else if (!BUS_I.rd)
        begin
            rd_data_r <= '0;
        end
        else if (hit(BUS_I.addr, wkr_pkg::TCS_ADDR))
        begin
            rd_data_r <= tcs_byte;
        end
        else if (hit(BUS_I.addr, wkr_pkg::CNT_ADDR))
        begin
            rd_data_r <= cnt_r;
        end
        else if (hit(BUS_I.addr, wkr_pkg::RCS_ADDR))
        begin
            rd_data_r <= rcs_byte;
        end
        else
        begin
            rd_data_r <= '0;
        end
    end

    assign RD_DATA_O = rd_data_r;
    assign WDT_RESET_O = wdt_reset_r;
    assign RESET_SELECT_O = rcs_r.reset_select_bit;

    // Byte writes near the reset register leave bits 6 and 5 unchanged
    byte_write_ignored_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (BUS_I.wr && !BUS_I.word && (hit(BUS_I.addr, wkr_pkg::RCS_ADDR)
            || hit(BUS_I.addr, wkr_pkg::RCS_WORD_ADDR)))
        |=> $stable(rcs_r.reset_enable_bit) && $stable(rcs_r.reset_select_bit))
        else $error("byte write changed reset control bits");

    // Clear key drops the flag and keeps the other bits
    clear_key_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (rcs_clear && !(overflow && wdmode_r))
        |=> !rcs_r.ovf && $stable(rcs_r.reset_enable_bit) && $stable(rcs_r.reset_select_bit))
        else $error("clear key did not clear overflow cleanly");

    // Load key copies bits 6 and 5, flag untouched unless set
    load_key_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (rcs_load && !(overflow && wdmode_r))
        |=> rcs_r.reset_enable_bit == $past(BUS_I.wdata[wkr_pkg::RCS_RESET_ENABLE_BIT])
            && rcs_r.reset_select_bit == $past(BUS_I.wdata[wkr_pkg::RCS_RESET_SELECT_BIT])
            && $stable(rcs_r.ovf))
        else $error("load key did not load enable and select");

    // Reset register read returns its contents one cycle later
    rcs_read_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (BUS_I.rd && hit(BUS_I.addr, wkr_pkg::RCS_ADDR))
        |=> RD_DATA_O == {$past(rcs_r.ovf), $past(rcs_r.reset_enable_bit), $past(rcs_r.reset_select_bit), 5'h00})
        else $error("reset register read data wrong");

    // Timer control read shows every field in its place
    tcs_read_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (BUS_I.rd && hit(BUS_I.addr, wkr_pkg::TCS_ADDR))
        |=> RD_DATA_O == {$past(tcs_ovf_r), $past(wdmode_r), $past(tme_r), 2'h0,
            $past(cks_r)})
        else $error("timer control read data wrong");

    // Write beats a coincident increment
    write_wins_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (cnt_wr && tick) |=> cnt_r == $past(BUS_I.wdata[7:0]))
        else $error("counter increment beat the write");

    // Unknown key keeps every bit
    bad_key_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (rcs_word_wr && !rcs_load && !rcs_clear && !overflow)
        |=> $stable(rcs_r))
        else $error("unknown key altered reset register");

    // Watchdog overflow with enable gives a reset pulse
    reset_pulse_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (overflow && wdmode_r && rcs_r.reset_enable_bit) |=> WDT_RESET_O ##1 !WDT_RESET_O)
        else $error("watchdog reset pulse missing");

    // A clock pulse without a write steps the counter by one
    count_step_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (tick && !cnt_wr) |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter did not step on its clock pulse");

    // A stopped timer holds its count unless software writes it
    stopped_hold_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (!tme_r && !cnt_wr) |=> $stable(cnt_r))
        else $error("counter moved while the timer was stopped");

    // Read data stand for one cycle only and read zero otherwise
    read_idle_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !BUS_I.rd |=> RD_DATA_O == 8'h00)
        else $error("read data outside a read cycle");

    // Interval overflow sets the timer flag and never resets the chip
    interval_flag_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (overflow && !wdmode_r) |=> tcs_ovf_r && !WDT_RESET_O)
        else $error("interval overflow handled wrongly");
endmodule
